// [design/line_ctrl.sv]
/*
 * Strobe timing and line maintenance register bank with an AHB-Lite slave,
 * TDM slot timing, frame strobe generation and U-side maintenance controls.
 * Assumes one 10 MHz clock, an asynchronous active-low reset, single-word
 * AHB transfers, and a U-side transceiver that obeys the maintenance levels.
 */
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "line_ctrl_cfg.svh"

module line_ctrl
    import line_ctrl_pkg::*;
#(
    parameter int CLK_DIV = 4,
    parameter int FRAME_BITS = 64
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // TDM bus.
    input wire logic slot_tx_data,
    output logic slot_bus_bit_clock,
    output logic slot_bus_bit_clock_oe,
    output logic frame_strobe,
    output logic frame_strobe_oe,
    output logic slot_data_out,
    output logic slot_data_oe,
    // U-side maintenance.
    output logic u_tx_halt,
    output logic u_filter_clear,
    output logic u_rx_reset,
    output logic startup_tone_one,
    output logic u_internal_reset,
    output logic tx_reserved_1_6,
    output logic tx_reserved_1_5,
    output logic tx_reserved_2_5,
    output logic tx_reserved_6_4
);

    localparam int NSLOT = 6;

    // ----------------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------------
    logic [7:0] general_reg_0;
    logic [7:0] general_reg_2;
    logic [7:0] slot_flow_reg;
    logic [7:0] strobe_timing_reg;
    logic [7:0] maint_control_reg;
    logic [7:0] status_reg;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [7:0] rd_idx;
    logic [7:0] rd_val;
    logic [7:0] fwd_val;
    logic take;

    assign take = hsel & hready & htrans[1];
    assign rd_idx = 8'(haddr[31:2]);

    // Capture the address phase of a write for the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_idx <= 8'h00;
        end else if (hready) begin
            wr_pend <= take & hwrite;
            wr_idx <= rd_idx;
        end
    end

    // Store write data during the data phase; unmapped indices are ignored.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            general_reg_0 <= `RST_GENERAL_REG_0;
            general_reg_2 <= `RST_GENERAL_REG_2;
            slot_flow_reg <= `RST_SLOT_FLOW;
            strobe_timing_reg <= `RST_STROBE_TIMING;
            maint_control_reg <= `RST_MAINT_CONTROL;
        end else if (wr_pend) begin
            unique case (wr_idx)
                `IDX_GENERAL_REG_0: general_reg_0 <= hwdata[7:0];
                `IDX_GENERAL_REG_2: general_reg_2 <= hwdata[7:0];
                `IDX_SLOT_FLOW: slot_flow_reg <= hwdata[7:0];
                `IDX_STROBE_TIMING: strobe_timing_reg <= {4'h0, hwdata[3:0]};
                `IDX_MAINT_CONTROL: maint_control_reg <= {2'b00, hwdata[5:0]};
                default: ;
            endcase
        end
    end

    // Read mux; a write still in its data phase is forwarded.
    always_comb begin
        rd_val = 8'h00;
        unique case (rd_idx)
            `IDX_GENERAL_REG_0: rd_val = general_reg_0;
            `IDX_GENERAL_REG_2: rd_val = general_reg_2;
            `IDX_SLOT_FLOW: rd_val = slot_flow_reg;
            `IDX_STROBE_TIMING: rd_val = strobe_timing_reg;
            `IDX_MAINT_CONTROL: rd_val = maint_control_reg;
            `IDX_STATUS: rd_val = status_reg;
            default: rd_val = 8'h00;
        endcase
        fwd_val = rd_val;
        if (wr_pend && wr_idx == rd_idx && rd_idx != `IDX_STATUS) begin
            fwd_val = hwdata[7:0];
        end
    end

    // Read data is registered at the address phase edge; zero wait states.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (take && !hwrite) begin
                hrdata <= {24'h00_0000, fwd_val};
            end
        end
    end

    // ----------------------------------------------------------------------
    // Slot timing
    // ----------------------------------------------------------------------
    logic bus_enabled_n;
    logic any_slot_on;
    logic bus_on;
    logic [15:0] div_cnt;
    logic bit_tick;
    logic [6:0] bit_cnt;
    logic [6:0] slot_start [NSLOT];
    logic [6:0] slot_width [NSLOT];
    logic [NSLOT-1:0] in_slot;

    assign bus_enabled_n = general_reg_2[`BIT_TDM_BUS_ENABLE_N];
    assign any_slot_on = ~&slot_flow_reg[7:2];
    assign bus_on = ~bus_enabled_n & any_slot_on;
    assign bit_tick = div_cnt == 16'(2 * CLK_DIV - 1);

    // Bit clock divider, low half then high half; idle while bus is off.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt <= 16'h0000;
            bit_cnt <= 7'h00;
        end else if (!bus_on) begin
            div_cnt <= 16'h0000;
            bit_cnt <= 7'h00;
        end else if (bit_tick) begin
            div_cnt <= 16'h0000;
            if (bit_cnt == 7'(FRAME_BITS - 1)) begin
                bit_cnt <= 7'h00;
            end else begin
                bit_cnt <= bit_cnt + 7'h01;
            end
        end else begin
            div_cnt <= div_cnt + 16'h0001;
        end
    end

    assign slot_start[0] = `SLOT_ST_B1;
    assign slot_start[1] = `SLOT_ST_B2;
    assign slot_start[2] = `SLOT_ST_D;
    assign slot_start[3] = `SLOT_U_B1;
    assign slot_start[4] = `SLOT_U_B2;
    assign slot_start[5] = `SLOT_U_D;
    assign slot_width[0] = `WIDTH_B;
    assign slot_width[1] = `WIDTH_B;
    assign slot_width[2] = `WIDTH_D;
    assign slot_width[3] = `WIDTH_B;
    assign slot_width[4] = `WIDTH_B;
    assign slot_width[5] = `WIDTH_D;

    // Each slot drives only while its control bit is 0.
    for (genvar s = 0; s < NSLOT; s++) begin : g_slot
        assign in_slot[s] = ~slot_flow_reg[s+2]
            & bit_cnt >= slot_start[s]
            & bit_cnt < slot_start[s] + slot_width[s];
    end

    // TDM pin drivers; clock and strobe drive while the bus is enabled and any slot is on.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slot_bus_bit_clock <= 1'b0;
            slot_bus_bit_clock_oe <= 1'b0;
            frame_strobe_oe <= 1'b0;
            slot_data_out <= 1'b0;
            slot_data_oe <= 1'b0;
        end else begin
            slot_bus_bit_clock <= bus_on & (div_cnt >= 16'(CLK_DIV));
            slot_bus_bit_clock_oe <= bus_on;
            frame_strobe_oe <= bus_on;
            slot_data_out <= slot_tx_data;
            slot_data_oe <= bus_on & (|in_slot);
        end
    end

    // ----------------------------------------------------------------------
    // Frame strobe
    // ----------------------------------------------------------------------
    logic [2:0] pos_eff;
    logic pol_eff;
    logic [6:0] env_start;
    logic [6:0] env_width;
    logic env_valid;
    logic in_env;

    // New position and polarity load only while the bus runs.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pos_eff <= 3'(`RST_STROBE_TIMING);
            pol_eff <= 1'b1;
        end else if (bus_on) begin
            pos_eff <= strobe_timing_reg[2:0];
            pol_eff <= strobe_timing_reg[`BIT_STROBE_POLARITY];
        end
    end

    // Envelope placement per position code; other codes give no strobe.
    always_comb begin
        env_start = 7'h00;
        env_width = 7'h00;
        env_valid = 1'b1;
        unique case (pos_eff)
            POS_ST_2BD: begin
                env_start = `SLOT_ST_B1;
                env_width = `WIDTH_2BD;
            end
            POS_U_2BD: begin
                env_start = `SLOT_U_B1;
                env_width = `WIDTH_2BD;
            end
            POS_ST_B2: begin
                env_start = `SLOT_ST_B2;
                env_width = `WIDTH_B;
            end
            POS_U_D: begin
                env_start = `SLOT_U_D;
                env_width = `WIDTH_D;
            end
            POS_U_B1: begin
                env_start = `SLOT_U_B1;
                env_width = `WIDTH_B;
            end
            default: env_valid = 1'b0;
        endcase
    end

    assign in_env = bus_on & env_valid & bit_cnt >= env_start
        & bit_cnt < env_start + env_width;

    // Polarity applies the envelope sense.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_strobe <= 1'b0;
        end else begin
            frame_strobe <= pol_eff ? in_env : ~in_env;
        end
    end

    // ----------------------------------------------------------------------
    // Line maintenance
    // ----------------------------------------------------------------------
    logic auto_control_flow;
    logic filter_reset_n;
    logic insertion_loss_test_n;
    loss_test_e test_state;

    assign auto_control_flow = general_reg_0[`BIT_AUTO_CONTROL_FLOW];
    // Under automatic control the register reads back but acts as default.
    assign filter_reset_n = auto_control_flow
        | maint_control_reg[`BIT_FILTER_RESET_N];
    assign insertion_loss_test_n = auto_control_flow
        | maint_control_reg[`BIT_INS_LOSS_TEST_N];

    // Test arms on both bits 0 and runs once the filter reset is released.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            test_state <= TEST_IDLE;
        end else begin
            unique case (test_state)
                TEST_IDLE: begin
                    if (!filter_reset_n && !insertion_loss_test_n) begin
                        test_state <= TEST_ARMED;
                    end
                end
                TEST_ARMED: begin
                    if (insertion_loss_test_n) begin
                        test_state <= TEST_IDLE;
                    end else if (filter_reset_n) begin
                        test_state <= TEST_RUN;
                    end
                end
                TEST_RUN: begin
                    if (insertion_loss_test_n) begin
                        test_state <= TEST_IDLE;
                    end
                end
            endcase
        end
    end

    // Maintenance levels toward the U transceiver; timing recovery and the
    // S/T side have no input here, so a filter reset cannot reach them.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            u_tx_halt <= 1'b0;
            u_filter_clear <= 1'b0;
            u_rx_reset <= 1'b0;
            startup_tone_one <= 1'b0;
            u_internal_reset <= 1'b0;
        end else begin
            u_tx_halt <= ~filter_reset_n;
            u_filter_clear <= ~filter_reset_n;
            // Tone and receiver reset drop as soon as the test bit is
            // inactive, including when automatic control takes over.
            u_rx_reset <= test_state == TEST_RUN
                && !insertion_loss_test_n;
            startup_tone_one <= test_state == TEST_RUN
                && !insertion_loss_test_n;
            u_internal_reset <= test_state == TEST_RUN
                && insertion_loss_test_n;
        end
    end

    // Reserved overhead bits for the transmitted U frame.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_reserved_1_6 <= 1'b1;
            tx_reserved_1_5 <= 1'b1;
            tx_reserved_2_5 <= 1'b1;
            tx_reserved_6_4 <= 1'b1;
        end else begin
            tx_reserved_1_6 <= auto_control_flow
                | maint_control_reg[`BIT_TX_RES_1_6];
            tx_reserved_1_5 <= auto_control_flow
                | maint_control_reg[`BIT_TX_RES_1_5];
            tx_reserved_2_5 <= auto_control_flow
                | maint_control_reg[`BIT_TX_RES_2_5];
            tx_reserved_6_4 <= auto_control_flow
                | maint_control_reg[`BIT_TX_RES_6_4];
        end
    end

    // Status shows the live test state and strobe setting in use.
    assign status_reg = {pos_eff, pol_eff, bus_on, frame_strobe,
        test_state};

    // ----------------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------------
    AST_CFG_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        !bus_on |=> $stable(pos_eff) && $stable(pol_eff))
        else $error("Strobe setting changed while bus off.");

    AST_CODE0_WIDTH: assert property (@(posedge hclk) disable iff (!hresetn)
        pos_eff == 3'h0 && bus_on |-> in_env == (bit_cnt < 7'd18))
        else $error("Code 000 envelope wrong.");

    AST_CODE2: assert property (@(posedge hclk) disable iff (!hresetn)
        pos_eff == 3'h2 && bus_on |-> in_env
        == (bit_cnt >= 7'd8 && bit_cnt < 7'd16))
        else $error("Code 010 envelope wrong.");

    AST_CODE3: assert property (@(posedge hclk) disable iff (!hresetn)
        pos_eff == 3'h3 && bus_on |-> in_env
        == (bit_cnt == 7'd34 || bit_cnt == 7'd35))
        else $error("Code 011 envelope wrong.");

    AST_CODE7: assert property (@(posedge hclk) disable iff (!hresetn)
        pos_eff == 3'h7 && bus_on |-> in_env
        == (bit_cnt >= 7'd18 && bit_cnt < 7'd26))
        else $error("Code 111 envelope wrong.");

    AST_POLARITY: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> frame_strobe == ($past(pol_eff) ~^ $past(in_env)))
        else $error("Strobe polarity wrong.");

    AST_AUTO_IGNORE: assert property (@(posedge hclk) disable iff (!hresetn)
        auto_control_flow |=> !u_tx_halt && !startup_tone_one
        && tx_reserved_6_4)
        else $error("Maintenance acted under automatic control.");

    AST_TEST_EXIT: assert property (@(posedge hclk) disable iff (!hresetn)
        test_state == TEST_RUN && insertion_loss_test_n
        |=> u_internal_reset ##1 !u_internal_reset)
        else $error("Internal reset pulse missing.");

    AST_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
        !filter_reset_n [*2] |-> u_tx_halt && u_filter_clear)
        else $error("Filter reset did not quiet transmitter.");

    AST_SLOT_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        !bus_on |=> !slot_data_oe && !frame_strobe_oe)
        else $error("TDM pins driven with bus off.");

endmodule

// [inc/line_ctrl_cfg.svh]
/*
 * Register offsets, field positions, reset values and timing counts for the
 * strobe timing and line maintenance register bank.
 * Assumes a 32-bit AHB-Lite bus; byte address is four times the index.
 */
`ifndef LINE_CTRL_CFG_SVH
`define LINE_CTRL_CFG_SVH

// --------------------------------------------------------------------------
// Register indices (byte address = index * 4)
// --------------------------------------------------------------------------
`define IDX_GENERAL_REG_0 8'h00
`define IDX_GENERAL_REG_2 8'h02
`define IDX_SLOT_FLOW 8'h04
`define IDX_STROBE_TIMING 8'h05
`define IDX_MAINT_CONTROL 8'h06
`define IDX_STATUS 8'h0a

// --------------------------------------------------------------------------
// Field positions and reset values
// --------------------------------------------------------------------------
`define BIT_AUTO_CONTROL_FLOW 3
`define BIT_TDM_BUS_ENABLE_N 5
`define BIT_STROBE_POLARITY 3
`define BIT_INS_LOSS_TEST_N 0
`define BIT_FILTER_RESET_N 1
`define BIT_TX_RES_1_5 2
`define BIT_TX_RES_1_6 3
`define BIT_TX_RES_2_5 4
`define BIT_TX_RES_6_4 5
`define RST_GENERAL_REG_0 8'h00
`define RST_GENERAL_REG_2 8'h20
`define RST_SLOT_FLOW 8'hff
`define RST_STROBE_TIMING 8'h0f
`define RST_MAINT_CONTROL 8'h3f

// --------------------------------------------------------------------------
// Slot layout in bit periods from frame start
// --------------------------------------------------------------------------
`define SLOT_ST_B1 7'd0
`define SLOT_ST_B2 7'd8
`define SLOT_ST_D 7'd16
`define SLOT_U_B1 7'd18
`define SLOT_U_B2 7'd26
`define SLOT_U_D 7'd34
`define WIDTH_B 7'd8
`define WIDTH_D 7'd2
`define WIDTH_2BD 7'd18

`endif

// [inc/line_ctrl_pkg.sv]
/*
 * Types shared by the strobe timing and line maintenance register bank.
 * Assumes nothing of its surroundings.
 */
package line_ctrl_pkg;

    // Insertion loss test sequencing.
    typedef enum logic [1:0] {
        TEST_IDLE,
        TEST_ARMED,
        TEST_RUN
    } loss_test_e;

    // Strobe position codes.
    typedef enum logic [2:0] {
        POS_ST_2BD = 3'h0,
        POS_U_2BD = 3'h1,
        POS_ST_B2 = 3'h2,
        POS_U_D = 3'h3,
        POS_U_B1 = 3'h7
    } strobe_pos_e;

endpackage

// [testbench/line_ctrl_bench.sv]
/*
 * Self-checking bench for the strobe timing and line maintenance bank.
 * Assumes the design, its package, the cfg header and the TDM peer model.
 */
`timescale 1ns/1ps
`include "line_ctrl_cfg.svh"

module line_ctrl_bench;
    // ----------------------------------------------------------------------
    // Signals, instances and bus tasks
    // ----------------------------------------------------------------------
    localparam int CLK_DIV = 1;
    localparam int FRAME_BITS = 40;
    localparam int FRAME_CYC = 2 * CLK_DIV * FRAME_BITS;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic active_high = 1'b1;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, slot_tx_data, bclk, bclk_oe, fs, fs_oe;
    logic sdo, sdo_oe, halt, fclr, rx_rst, tone, ureset;
    logic r16, r15, r25, r64;
    logic [7:0] last_len;
    logic [31:0] seed = 32'hf6f7;
    int mismatches = 0;
    int checked = 0;
    int pulses = 0;
    wire [3:0] res4 = {r64, r25, r16, r15};

    // Clock of 100 ns period.
    always #50 hclk = ~hclk;

    // Internal reset pulses seen at clock edges.
    always @(posedge hclk) begin
        if (ureset === 1'b1) begin
            pulses++;
        end
    end

    line_ctrl #(.CLK_DIV(CLK_DIV), .FRAME_BITS(FRAME_BITS)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .slot_tx_data(slot_tx_data),
        .slot_bus_bit_clock(bclk), .slot_bus_bit_clock_oe(bclk_oe),
        .frame_strobe(fs), .frame_strobe_oe(fs_oe), .slot_data_out(sdo),
        .slot_data_oe(sdo_oe), .u_tx_halt(halt), .u_filter_clear(fclr),
        .u_rx_reset(rx_rst), .startup_tone_one(tone),
        .u_internal_reset(ureset), .tx_reserved_1_6(r16),
        .tx_reserved_1_5(r15), .tx_reserved_2_5(r25), .tx_reserved_6_4(r64)
    );

    tdm_peer peer (
        .hclk(hclk), .hresetn(hresetn), .frame_strobe(fs),
        .frame_strobe_oe(fs_oe), .active_high(active_high),
        .slot_tx_data(slot_tx_data), .last_len(last_len)
    );

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One comparison of eight bits.
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask

    // Waits for hready under a bound; running out ends the run.
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (hreadyout !== 1'b1) begin
            mismatches++;
            wrap_up();
        end
    endtask

    // One single-word transfer; read data lands in rd.
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    // Envelope length in clocks for a position code.
    function automatic logic [7:0] exp_len(input logic [2:0] c);
        logic [6:0] bits;
        case (c)
            3'h2, 3'h7: bits = `WIDTH_B;
            3'h3: bits = `WIDTH_D;
            default: bits = `WIDTH_2BD;
        endcase
        return 8'(2 * CLK_DIV * bits);
    endfunction

    // ----------------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------------
    initial begin
        int n;
        int k;
        int h;
        logic p;
        logic [2:0] c;
        logic [7:0] e, w;
        logic [31:0] adr [6] = '{32'h0, 32'h8, 32'h10, 32'h14, 32'h18, 32'h3c};
        logic [7:0] dfl [6] = '{8'h0, 8'h20, 8'hff, 8'h0f, 8'h3f, 8'h0};
        logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        chk("reserved", 8'hf, {4'h0, res4});
        chk("drive off", 8'h0, {6'h0, bclk_oe, fs_oe});
        bus(1'b1, 32'h3c, 32'hff);
        for (k = 0; k < 6; k++) begin
            bus(1'b0, adr[k], 32'h0);
            chk("reset value", dfl[k], rd[7:0]);
            chk("hresp", 8'h0, {7'h0, hresp});
        end
        $display("done reset values");
        bus(1'b1, 32'h14, 32'h02);
        bus(1'b1, 32'h08, 32'h00);
        repeat (3) @(posedge hclk);
        chk("no slot", 8'h0, {6'h0, bclk_oe, fs_oe});
        bus(1'b0, 32'h28, 32'h0);
        chk("frozen", 8'hf, {4'h0, rd[7:4]});
        bus(1'b1, 32'h10, 32'hfb);
        repeat (3) @(posedge hclk);
        bus(1'b0, 32'h28, 32'h0);
        chk("loaded", 8'h4, {4'h0, rd[7:4]});
        chk("slot on", 8'h3, {6'h0, bclk_oe, fs_oe});
        $display("done bus enable");
        n = 0;
        h = 0;
        @(posedge hclk);
        p = slot_tx_data;
        for (k = 0; k < 2 * FRAME_CYC; k++) begin
            @(posedge hclk);
            n += int'(sdo_oe);
            h += int'(bclk === 1'b1);
            if (sdo_oe === 1'b1) begin
                chk("slot data", {7'h0, p}, {7'h0, sdo});
            end
            p = slot_tx_data;
        end
        chk("slot cycles", 8'(4 * CLK_DIV * `WIDTH_B), 8'(n));
        chk("bit clock high", 8'(2 * CLK_DIV * FRAME_BITS), 8'(h));
        $display("done slot data");
        for (k = 0; k < 10; k++) begin
            c = codes[k / 2];
            active_high <= k[0];
            bus(1'b1, 32'h14, {28'h0, k[0], c});
            repeat (2 * FRAME_CYC + 4) @(posedge hclk);
            e = exp_len(c);
            chk("len", e, last_len);
            bus(1'b0, 32'h28, 32'h0);
            chk("in use", {4'h0, c, k[0]}, rd[7:0] >> 4);
        end
        $display("done strobe codes");
        bus(1'b1, 32'h18, 32'h3d);
        repeat (3) @(posedge hclk);
        chk("halt", 8'h3, {6'h0, halt, fclr});
        chk("kept", 8'h1f, {3'h0, bclk_oe, res4});
        bus(1'b0, 32'h14, 32'h0);
        chk("reg kept", 8'h0f, rd[7:0]);
        bus(1'b1, 32'h18, 32'h3c);
        bus(1'b1, 32'h18, 32'h3e);
        repeat (3) @(posedge hclk);
        chk("test run", 8'h3, {5'h0, halt, rx_rst, tone});
        n = pulses;
        bus(1'b1, 32'h18, 32'h3f);
        repeat (4) @(posedge hclk);
        chk("pulse", 8'h1, 8'(pulses - n));
        chk("test off", 8'h0, {6'h0, rx_rst, tone});
        for (k = 0; k < 4; k++) begin
            w = 8'($random(seed));
            w[1:0] = 2'h3;
            bus(1'b1, 32'h18, {24'h0, w});
            repeat (3) @(posedge hclk);
            chk("reserved", {4'h0, w[5:2]}, {4'h0, res4});
        end
        $display("done maintenance");
        bus(1'b1, 32'h00, 32'h08);
        bus(1'b1, 32'h18, 32'h00);
        repeat (3) @(posedge hclk);
        chk("auto", 8'h0f, {2'h0, halt, tone, res4});
        bus(1'b0, 32'h18, 32'h0);
        chk("auto readback", 8'h0, rd[7:0]);
        $display("done auto mode");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        bus(1'b0, 32'h18, 32'h0);
        chk("second reset", 8'h3f, rd[7:0]);
        $display("done second reset");
        wrap_up();
    end
endmodule

// [testbench/tdm_peer.sv]
/*
 * TDM bus peer: feeds slot data to the block and measures the strobe.
 * Assumes it shares the block's clock and sees the strobe pin directly.
 */
`timescale 1ns/1ps

module tdm_peer (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Strobe pin and the level at which it is active.
    input wire logic frame_strobe,
    input wire logic frame_strobe_oe,
    input wire logic active_high,
    // Data towards the block and length of the last envelope.
    output logic slot_tx_data,
    output logic [7:0] last_len
);
    // ----------------------------------------------------------------------
    // Data source and envelope meter
    // ----------------------------------------------------------------------
    logic [7:0] lfsr;
    logic [7:0] run;

    // Data shifts every cycle so that a stale copy cannot match.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lfsr <= 8'h5a;
        end else begin
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        end
    end
    assign slot_tx_data = lfsr[0];

    // Length in clocks of each run at the active level while driven.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run <= 8'h0;
            last_len <= 8'h0;
        end else if (frame_strobe_oe && frame_strobe == active_high) begin
            run <= run + 8'h1;
        end else begin
            if (run != 8'h0) begin
                last_len <= run;
            end
            run <= 8'h0;
        end
    end
endmodule
